// [pkg/rfcrc_params.svh]
`ifndef RFCRC_PARAMS_SVH
`define RFCRC_PARAMS_SVH
// Behaviour
// - Type code 0/1/2 picks CRC5/CRC8/CRC16
// - Transmit enable appends CRC to frame
// - Transmit invert flips appended CRC bits
// - Transmit preset codes give fixed CRC16 starts
// - Receive preset uses same code mapping
// - CRC8 and CRC5 presets per code
// - Code 6 takes user value from NV area
// - Force-write passes received CRC to FIFO
// - Receive invert checks against inverted CRC
// - Receive enable raises error on mismatch
// - Receive disabled: calculate, error flag untouched

// ----------------------------------------
// Register map
// ----------------------------------------
`define RFCRC_ADDR_TX_CFG 8'h2c
`define RFCRC_ADDR_RX_CFG 8'h2d
`define RFCRC_ADDR_STATUS 8'h70
`define RFCRC_ADDR_MASK 8'h71
`define RFCRC_ADDR_CALC_LO 8'h72
`define RFCRC_ADDR_CALC_HI 8'h73
`define RFCRC_CFG_RESET 8'h00
`define RFCRC_TX_CFG_MASK 8'h7f
`define RFCRC_ST_WIDTH 3
`define RFCRC_ST_TX_DONE 0
`define RFCRC_ST_RX_DONE 1
`define RFCRC_ST_RX_ERR 2
`define RFCRC_CRC_RESET 16'h0000

// ----------------------------------------
// Preset values
// ----------------------------------------
`define RFCRC_P16_0 16'h0000
`define RFCRC_P16_1 16'h6363
`define RFCRC_P16_2 16'ha671
`define RFCRC_P16_3 16'hfffe
`define RFCRC_P16_7 16'hffff
`define RFCRC_P8_0 8'h00
`define RFCRC_P8_1 8'h12
`define RFCRC_P8_2 8'hbf
`define RFCRC_P8_3 8'hfd
`define RFCRC_P8_7 8'hff
`define RFCRC_P5_0 5'h00
`define RFCRC_P5_1 5'h12
`define RFCRC_P5_7 5'h1f
`define RFCRC_P_UNDEF 16'h0000
`endif

// [pkg/rfcrc_pkg.sv]
package rfcrc_pkg;
  typedef enum logic [1:0] {
    CRC5 = 2'b00,
    CRC8 = 2'b01,
    CRC16 = 2'b10,
    CRC_RSVD = 2'b11
  } rfcrc_type_t;

  typedef enum logic [2:0] {
    PRE_0 = 3'b000,
    PRE_1 = 3'b001,
    PRE_2 = 3'b010,
    PRE_3 = 3'b011,
    PRE_4 = 3'b100,
    PRE_5 = 3'b101,
    PRE_USER = 3'b110,
    PRE_7 = 3'b111
  } rfcrc_code_t;

  typedef enum logic {
    TX_PASS = 1'b0,
    TX_APPEND = 1'b1
  } rfcrc_tx_state_t;

  typedef struct packed {
    logic to_fifo;
    rfcrc_code_t init_code;
    rfcrc_type_t poly_sel;
    logic invert;
    logic enable;
  } rfcrc_cfg_t;

  typedef struct packed {
    logic [15:0] crc16;
    logic [7:0] crc8;
    logic [4:0] crc5;
  } rfcrc_user_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic last;
  } rfcrc_stream_t;

  function automatic logic [3:0] rfcrc_msb(input rfcrc_type_t t);
    return (t == CRC5) ? 4'h4 : (t == CRC8) ? 4'h7 : 4'hf;
  endfunction

  function automatic logic [15:0] rfcrc_mask(input rfcrc_type_t t);
    return (t == CRC5) ? 16'h001f : (t == CRC8) ? 16'h00ff :
      (t == CRC16) ? 16'hffff : 16'h0000;
  endfunction
endpackage

// [hdl/rfcrc_preset.sv]
`timescale 1ns/1ps
`include "rfcrc_params.svh"
module rfcrc_preset (
  input wire rfcrc_pkg::rfcrc_type_t i_type,
  input wire rfcrc_pkg::rfcrc_code_t i_code,
  input wire rfcrc_pkg::rfcrc_user_t i_user,
  output logic [15:0] o_preset
);
  // ----------------------------------------
  // Code to start value, per CRC type
  // ----------------------------------------
  always_comb
  begin
    o_preset = `RFCRC_P_UNDEF;
    unique case (i_code)
      rfcrc_pkg::PRE_0:
        o_preset = (i_type == rfcrc_pkg::CRC16) ? `RFCRC_P16_0 :
          (i_type == rfcrc_pkg::CRC8) ? {8'h00, `RFCRC_P8_0} : {11'h000, `RFCRC_P5_0};
      rfcrc_pkg::PRE_1:
        o_preset = (i_type == rfcrc_pkg::CRC16) ? `RFCRC_P16_1 :
          (i_type == rfcrc_pkg::CRC8) ? {8'h00, `RFCRC_P8_1} : {11'h000, `RFCRC_P5_1};
      rfcrc_pkg::PRE_2:
        o_preset = (i_type == rfcrc_pkg::CRC16) ? `RFCRC_P16_2 :
          (i_type == rfcrc_pkg::CRC8) ? {8'h00, `RFCRC_P8_2} : `RFCRC_P_UNDEF;
      rfcrc_pkg::PRE_3:
        o_preset = (i_type == rfcrc_pkg::CRC16) ? `RFCRC_P16_3 :
          (i_type == rfcrc_pkg::CRC8) ? {8'h00, `RFCRC_P8_3} : `RFCRC_P_UNDEF;
      rfcrc_pkg::PRE_4, rfcrc_pkg::PRE_5:
        o_preset = `RFCRC_P_UNDEF;
      rfcrc_pkg::PRE_USER:
        o_preset = (i_type == rfcrc_pkg::CRC16) ? i_user.crc16 :
          (i_type == rfcrc_pkg::CRC8) ? {8'h00, i_user.crc8} : {11'h000, i_user.crc5};
      rfcrc_pkg::PRE_7:
        o_preset = (i_type == rfcrc_pkg::CRC16) ? `RFCRC_P16_7 :
          (i_type == rfcrc_pkg::CRC8) ? {8'h00, `RFCRC_P8_7} : {11'h000, `RFCRC_P5_7};
    endcase
    if (i_type == rfcrc_pkg::CRC_RSVD)
      o_preset = `RFCRC_P_UNDEF;
  end
endmodule

// [hdl/rfcrc_engine.sv]
`timescale 1ns/1ps
`include "rfcrc_params.svh"
module rfcrc_engine #(
  parameter logic [15:0] POLY16 = 16'h1021,
  parameter logic [7:0] POLY8 = 8'h1d,
  parameter logic [4:0] POLY5 = 5'h09
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic i_shift,
  input wire logic i_bit,
  input wire rfcrc_pkg::rfcrc_type_t i_type,
  input wire logic [15:0] i_preset,
  output logic [15:0] o_crc
);
  logic [15:0] next_crc;

  // ----------------------------------------
  // Bit-serial shift, MSB first
  // ----------------------------------------
  always_comb
  begin
    logic [15:0] base;
    logic [15:0] poly;
    logic fb;
    base = i_load ? i_preset : o_crc;
    poly = POLY16;
    fb = 1'b0;
    if (i_type == rfcrc_pkg::CRC5)
      poly = {11'h000, POLY5};
    else if (i_type == rfcrc_pkg::CRC8)
      poly = {8'h00, POLY8};
    fb = base[rfcrc_pkg::rfcrc_msb(i_type)] ^ i_bit;
    next_crc = base;
    if (i_shift)
      next_crc = ({base[14:0], 1'b0} ^ (fb ? poly : 16'h0000)) &
        rfcrc_pkg::rfcrc_mask(i_type);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_crc <= `RFCRC_CRC_RESET;
    else if (i_ce)
      o_crc <= next_crc;
  end
endmodule

// [hdl/rfcrc_top.sv]
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "rfcrc_params.svh"
module rfcrc_top (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic O_IRQ,
  input wire rfcrc_pkg::rfcrc_user_t I_USER_PRESET,
  input wire logic I_TX_START,
  input wire rfcrc_pkg::rfcrc_stream_t I_TX,
  output logic O_TX_READY,
  output rfcrc_pkg::rfcrc_stream_t O_TX,
  output logic O_TX_CRC,
  input wire logic I_RX_START,
  input wire rfcrc_pkg::rfcrc_stream_t I_RX,
  input wire logic I_RX_CRC,
  output rfcrc_pkg::rfcrc_stream_t O_RX,
  output logic O_RX_CRC,
  output logic O_RX_DONE,
  output logic O_RX_CRC_ERR
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else if (I_CE)
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  rfcrc_pkg::rfcrc_cfg_t tx_cfg, next_tx_cfg, rx_cfg, next_rx_cfg;
  logic [`RFCRC_ST_WIDTH-1:0] status, next_status, irq_mask, next_irq_mask;
  logic [7:0] next_rdata;
  logic [15:0] tx_crc, rx_crc;
  logic tx_done, rx_pend, next_rx_err;

  always_comb
  begin
    next_tx_cfg = tx_cfg;
    next_rx_cfg = rx_cfg;
    next_irq_mask = irq_mask;
    next_status = status;
    next_rdata = 8'h00;
    if (I_WR)
    begin
      case (I_ADDR)
        `RFCRC_ADDR_TX_CFG: next_tx_cfg = rfcrc_pkg::rfcrc_cfg_t'(I_WDATA & `RFCRC_TX_CFG_MASK);
        `RFCRC_ADDR_RX_CFG: next_rx_cfg = rfcrc_pkg::rfcrc_cfg_t'(I_WDATA);
        `RFCRC_ADDR_MASK: next_irq_mask = I_WDATA[`RFCRC_ST_WIDTH-1:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    if (I_RD)
    begin
      case (I_ADDR)
        `RFCRC_ADDR_TX_CFG: next_rdata = tx_cfg;
        `RFCRC_ADDR_RX_CFG: next_rdata = rx_cfg;
        `RFCRC_ADDR_STATUS:
        begin
          next_rdata = 8'(status);
          next_status = '0;
        end
        `RFCRC_ADDR_MASK: next_rdata = 8'(irq_mask);
        `RFCRC_ADDR_CALC_LO: next_rdata = rx_crc[7:0];
        `RFCRC_ADDR_CALC_HI: next_rdata = rx_crc[15:8];
        default: next_rdata = 8'h00;
      endcase
    end
    // Set wins over read clear
    next_status[`RFCRC_ST_TX_DONE] = next_status[`RFCRC_ST_TX_DONE] | tx_done;
    next_status[`RFCRC_ST_RX_DONE] = next_status[`RFCRC_ST_RX_DONE] | rx_pend;
    next_status[`RFCRC_ST_RX_ERR] = next_status[`RFCRC_ST_RX_ERR] | next_rx_err;
  end

  always_ff @(posedge I_MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_cfg <= `RFCRC_CFG_RESET;
      rx_cfg <= `RFCRC_CFG_RESET;
      irq_mask <= '0;
      status <= '0;
      O_RDATA <= 8'h00;
    end
    else if (I_CE)
    begin
      tx_cfg <= next_tx_cfg;
      rx_cfg <= next_rx_cfg;
      irq_mask <= next_irq_mask;
      status <= next_status;
      O_RDATA <= next_rdata;
    end
  end

  assign O_IRQ = |(status & irq_mask);

  // ----------------------------------------
  // Start values and CRC engines
  // ----------------------------------------
  logic [15:0] tx_preset, rx_preset;
  logic tx_load, tx_shift, rx_load, rx_shift;

  rfcrc_preset u_tx_preset (
    .i_type(tx_cfg.poly_sel),
    .i_code(tx_cfg.init_code),
    .i_user(I_USER_PRESET),
    .o_preset(tx_preset)
  );

  rfcrc_preset u_rx_preset (
    .i_type(rx_cfg.poly_sel),
    .i_code(rx_cfg.init_code),
    .i_user(I_USER_PRESET),
    .o_preset(rx_preset)
  );

  rfcrc_engine u_tx_engine (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_ce(I_CE),
    .i_load(tx_load),
    .i_shift(tx_shift),
    .i_bit(I_TX.data),
    .i_type(tx_cfg.poly_sel),
    .i_preset(tx_preset),
    .o_crc(tx_crc)
  );

  rfcrc_engine u_rx_engine (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_ce(I_CE),
    .i_load(rx_load),
    .i_shift(rx_shift),
    .i_bit(I_RX.data),
    .i_type(rx_cfg.poly_sel),
    .i_preset(rx_preset),
    .o_crc(rx_crc)
  );

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  rfcrc_pkg::rfcrc_tx_state_t tx_state, next_tx_state;
  rfcrc_pkg::rfcrc_stream_t next_tx_out;
  logic [3:0] tx_cnt, next_tx_cnt;
  logic next_tx_is_crc, tx_take, tx_crc_bit, tx_append_on;

  assign O_TX_READY = I_CE && rst_n && (tx_state == rfcrc_pkg::TX_PASS);
  assign tx_take = O_TX_READY && I_TX.valid;
  assign tx_load = O_TX_READY && I_TX_START;
  assign tx_shift = tx_take;
  assign tx_crc_bit = tx_crc[tx_cnt];
  assign tx_append_on = tx_cfg.enable && (tx_cfg.poly_sel != rfcrc_pkg::CRC_RSVD);

  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_cnt = tx_cnt;
    next_tx_out = '0;
    next_tx_is_crc = 1'b0;
    tx_done = 1'b0;
    unique case (tx_state)
      rfcrc_pkg::TX_PASS:
      begin
        if (tx_take)
        begin
          next_tx_out.valid = 1'b1;
          next_tx_out.data = I_TX.data;
          next_tx_out.last = I_TX.last && !tx_append_on;
          tx_done = I_TX.last && !tx_append_on;
          if (I_TX.last && tx_append_on)
          begin
            next_tx_state = rfcrc_pkg::TX_APPEND;
            next_tx_cnt = rfcrc_pkg::rfcrc_msb(tx_cfg.poly_sel);
          end
        end
      end
      rfcrc_pkg::TX_APPEND:
      begin
        next_tx_out.valid = 1'b1;
        next_tx_out.data = tx_crc_bit ^ tx_cfg.invert;
        next_tx_out.last = (tx_cnt == 4'h0);
        next_tx_is_crc = 1'b1;
        next_tx_cnt = tx_cnt - 4'h1;
        if (tx_cnt == 4'h0)
        begin
          next_tx_state = rfcrc_pkg::TX_PASS;
          tx_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state <= rfcrc_pkg::TX_PASS;
      tx_cnt <= 4'h0;
      O_TX <= '0;
      O_TX_CRC <= 1'b0;
    end
    else if (I_CE)
    begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      O_TX <= next_tx_out;
      O_TX_CRC <= next_tx_is_crc;
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  rfcrc_pkg::rfcrc_stream_t next_rx_out;
  logic [15:0] rx_rcv, next_rx_rcv, rx_mask, rx_expect;
  logic next_rx_pend, next_rx_is_crc, rx_mismatch;

  assign rx_load = I_RX_START;
  assign rx_shift = I_RX.valid && !I_RX_CRC;
  assign rx_mask = rfcrc_pkg::rfcrc_mask(rx_cfg.poly_sel);
  assign rx_expect = rx_crc ^ {16{rx_cfg.invert}};
  assign rx_mismatch = (rx_rcv & rx_mask) != (rx_expect & rx_mask);

  always_comb
  begin
    next_rx_rcv = rx_rcv;
    if (I_RX_START)
      next_rx_rcv = '0;
    if (I_RX.valid && I_RX_CRC)
      next_rx_rcv = {next_rx_rcv[14:0], I_RX.data};
    next_rx_pend = I_RX.valid && I_RX.last;
    next_rx_out.valid = I_RX.valid && (!I_RX_CRC || rx_cfg.to_fifo);
    next_rx_out.data = I_RX.data;
    next_rx_out.last = I_RX.last;
    next_rx_is_crc = I_RX.valid && I_RX_CRC;
    next_rx_err = rx_pend && rx_cfg.enable && rx_mismatch;
  end

  always_ff @(posedge I_MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_rcv <= 16'h0000;
      rx_pend <= 1'b0;
      O_RX <= '0;
      O_RX_CRC <= 1'b0;
      O_RX_DONE <= 1'b0;
      O_RX_CRC_ERR <= 1'b0;
    end
    else if (I_CE)
    begin
      rx_rcv <= next_rx_rcv;
      rx_pend <= next_rx_pend;
      O_RX <= next_rx_out;
      O_RX_CRC <= next_rx_is_crc;
      O_RX_DONE <= rx_pend;
      O_RX_CRC_ERR <= next_rx_err;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_MCLK iff I_CE);
  endclocking
  default disable iff (!rst_n);

  sequence s_tx_last_crc;
    tx_take && I_TX.last && tx_append_on;
  endsequence

  sequence s_crc_first;
    O_TX.valid && O_TX_CRC && !O_TX.last;
  endsequence

  sequence s_rx_check;
    rx_pend && rx_cfg.enable && (rx_cfg.poly_sel != rfcrc_pkg::CRC_RSVD);
  endsequence

  chk_tx_append: assert property (s_tx_last_crc |=> ##1 s_crc_first)
    else $error("CRC not appended after last data bit");
  chk_append_len: assert property (s_tx_last_crc ##0 (tx_cfg.poly_sel == rfcrc_pkg::CRC8)
    |=> ##8 (O_TX.valid && O_TX_CRC && O_TX.last))
    else $error("CRC8 append length wrong");
  chk_crc5_width: assert property ((tx_shift && tx_cfg.poly_sel == rfcrc_pkg::CRC5)
    |=> (tx_crc[15:5] == 11'h000))
    else $error("CRC5 register exceeds five bits");
  chk_tx_invert: assert property ((tx_state == rfcrc_pkg::TX_APPEND)
    |=> (O_TX.data == ($past(tx_crc_bit) ^ $past(tx_cfg.invert))))
    else $error("Appended CRC bit polarity wrong");
  chk_tx_preset: assert property ((tx_load && !tx_shift && tx_cfg.poly_sel == rfcrc_pkg::CRC16
    && tx_cfg.init_code == rfcrc_pkg::PRE_1) |=> (tx_crc == `RFCRC_P16_1))
    else $error("Transmit CRC16 preset wrong");
  chk_rx_preset: assert property ((rx_load && !rx_shift && rx_cfg.poly_sel == rfcrc_pkg::CRC16
    && rx_cfg.init_code == rfcrc_pkg::PRE_2) |=> (rx_crc == `RFCRC_P16_2))
    else $error("Receive CRC16 preset wrong");
  chk_crc5_preset: assert property ((rx_load && !rx_shift && rx_cfg.poly_sel == rfcrc_pkg::CRC5
    && rx_cfg.init_code == rfcrc_pkg::PRE_7) |=> (rx_crc == {11'h000, `RFCRC_P5_7}))
    else $error("Receive CRC5 preset wrong");
  chk_user_preset: assert property ((tx_load && !tx_shift && tx_cfg.poly_sel == rfcrc_pkg::CRC8
    && tx_cfg.init_code == rfcrc_pkg::PRE_USER)
    |=> (tx_crc == {8'h00, $past(I_USER_PRESET.crc8)}))
    else $error("User preset not loaded");
  chk_crc_fifo: assert property ((I_RX.valid && I_RX_CRC && !rx_cfg.to_fifo)
    |=> (!O_RX.valid && O_RX_CRC))
    else $error("CRC bit reached FIFO without force-write");
  chk_rx_invert: assert property ((s_rx_check ##0 rx_cfg.invert
    && ((rx_rcv & rx_mask) == (rx_crc & rx_mask))) |=> O_RX_CRC_ERR)
    else $error("Plain CRC accepted in inverted mode");
  chk_rx_error: assert property ((s_rx_check ##0 !rx_cfg.invert
    && ((rx_rcv & rx_mask) != (rx_crc & rx_mask)))
    |=> (O_RX_CRC_ERR && status[`RFCRC_ST_RX_ERR]))
    else $error("CRC mismatch not flagged");
  chk_err_hold: assert property ((rx_pend && !rx_cfg.enable)
    |=> (!O_RX_CRC_ERR && O_RX_DONE))
    else $error("Error flag moved with check disabled");
  chk_frame_load: assert property ((rx_load && !rx_shift)
    |=> (rx_crc == $past(rx_preset)))
    else $error("Frame start did not load preset");
endmodule

// [testbench/rfcrc_tag_model.sv]
`timescale 1ns/1ps
module rfcrc_tag_model (
  input wire logic i_clk,
  output logic o_start,
  output rfcrc_pkg::rfcrc_stream_t o_bit,
  output logic o_crc
);
  initial
  begin
    o_start = 1'b0;
    o_bit = '0;
    o_crc = 1'b0;
  end

  // --------------------------------
  // Frame sender, CRC bits msb first
  // --------------------------------
  task automatic send(input logic [15:0] dat, input int n, input logic [15:0] crc,
    input int w, input int gap);
    o_start <= 1'b1;
    @(posedge i_clk);
    o_start <= 1'b0;
    for (int i = 0; i < n + w; i++)
    begin
      o_bit.valid <= 1'b1;
      o_crc <= (i >= n);
      o_bit.data <= (i < n) ? dat[i] : crc[n + w - 1 - i];
      o_bit.last <= (i == n + w - 1);
      @(posedge i_clk);
      if (gap > 0)
      begin
        // Slow tag: line toggles while idle
        o_bit.valid <= 1'b0;
        o_bit.data <= ~o_bit.data;
        repeat (gap) @(posedge i_clk);
      end
    end
    o_bit.valid <= 1'b0;
    o_bit.data <= ~o_bit.data;
    o_bit.last <= 1'b0;
    o_crc <= 1'b0;
  endtask
endmodule

// [testbench/rf_frame_crc_gen_check_tb.sv]
`timescale 1ns/1ps
module rf_frame_crc_gen_check_tb;
  logic I_MCLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic I_CE = 1'b1;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic I_TX_START = 1'b0;
  logic [7:0] I_ADDR = 8'h00;
  logic [7:0] I_WDATA = 8'h00;
  logic [7:0] O_RDATA;
  logic O_IRQ, O_TX_READY, O_TX_CRC, I_RX_START, I_RX_CRC, O_RX_CRC, O_RX_DONE, O_RX_CRC_ERR;
  rfcrc_pkg::rfcrc_user_t I_USER_PRESET = '0;
  rfcrc_pkg::rfcrc_stream_t I_TX = '0;
  rfcrc_pkg::rfcrc_stream_t O_TX, I_RX, O_RX;
  int n_errors = 0;
  int check_count = 0;
  int seed = 17625;
  int nd, ne, nf, nc;
  int codes[6] = '{0, 1, 2, 3, 6, 7};
  logic txq[$];
  logic tcq[$];
  logic tlq[$];

  rfcrc_top i_dut (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ),
    .I_USER_PRESET(I_USER_PRESET), .I_TX_START(I_TX_START), .I_TX(I_TX),
    .O_TX_READY(O_TX_READY), .O_TX(O_TX), .O_TX_CRC(O_TX_CRC), .I_RX_START(I_RX_START),
    .I_RX(I_RX), .I_RX_CRC(I_RX_CRC), .O_RX(O_RX), .O_RX_CRC(O_RX_CRC),
    .O_RX_DONE(O_RX_DONE), .O_RX_CRC_ERR(O_RX_CRC_ERR));

  rfcrc_tag_model i_tag (.i_clk(I_MCLK), .o_start(I_RX_START), .o_bit(I_RX), .o_crc(I_RX_CRC));

  initial
  begin
    forever #4 I_MCLK = ~I_MCLK;
  end

  always @(posedge I_MCLK)
  begin
    if (O_TX.valid)
    begin
      txq.push_back(O_TX.data);
      tcq.push_back(O_TX_CRC);
      tlq.push_back(O_TX.last);
    end
    if (O_RX.valid)
      nf = nf + 1;
    if (O_RX_CRC)
      nc = nc + 1;
    if (O_RX_DONE)
      nd = nd + 1;
    if (O_RX_CRC_ERR)
      ne = ne + 1;
  end

  // --------------------------------
  // Reference CRC model
  // --------------------------------
  function automatic int wid(int t);
    return (t == 0) ? 5 : (t == 1) ? 8 : (t == 2) ? 16 : 0;
  endfunction

  function automatic int msk(int t);
    return (1 << wid(t)) - 1;
  endfunction

  function automatic int pre(int t, int c);
    int v;
    case (c)
      1: v = (t == 2) ? 16'h6363 : 16'h0012;
      2: v = (t == 2) ? 16'ha671 : 16'h00bf;
      3: v = (t == 2) ? 16'hfffe : 16'h00fd;
      6: v = (t == 2) ? I_USER_PRESET.crc16 : (t == 1) ? I_USER_PRESET.crc8 : I_USER_PRESET.crc5;
      7: v = 16'hffff;
      default: v = 0;
    endcase
    return v & msk(t);
  endfunction

  function automatic int step(int t, int crc, bit b);
    int w = wid(t);
    int p = (t == 0) ? 5'h09 : (t == 1) ? 8'h1d : 16'h1021;
    if (w == 0)
      return crc;
    return ((crc << 1) ^ ((((crc >> (w - 1)) & 1) ^ b) ? p : 0)) & msk(t);
  endfunction

  // --------------------------------
  // Reporting and bus tasks
  // --------------------------------
  task automatic close_out;
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic timeout(input string what);
    n_errors++;
    $display("[ERR] %s expected completion seen timeout", what);
    close_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
    @(posedge I_MCLK);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    @(negedge I_MCLK);
    chk("register read", {8'h00, e}, {8'h00, O_RDATA});
    @(posedge I_MCLK);
  endtask

  // --------------------------------
  // Transmit frame
  // --------------------------------
  task automatic tx_frame(input int t, input int c, input bit inv, input bit en);
    int n, crc, w, k;
    bit b;
    bit d[$];
    logic [7:0] m;
    n = 1 + $unsigned($random(seed)) % 12;
    m = 8'($random(seed)) & 8'h07;
    wr(8'h71, m);
    wr(8'h2c, {1'b0, 3'(c), 2'(t), inv, en});
    txq.delete();
    tcq.delete();
    tlq.delete();
    crc = pre(t, c);
    I_TX_START <= 1'b1;
    @(posedge I_MCLK);
    I_TX_START <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      b = $random(seed);
      d.push_back(b);
      crc = step(t, crc, b);
      I_TX <= {1'b1, b, i == n - 1};
      @(posedge I_MCLK);
    end
    I_TX <= '0;
    w = en ? wid(t) : 0;
    if (inv)
      crc = ~crc & msk(t);
    for (int i = w - 1; i >= 0; i--)
      d.push_back((crc >> i) & 1);
    for (k = 0; k < 40; k++)
    begin
      @(negedge I_MCLK);
      if (txq.size() >= d.size() && O_TX_READY)
        break;
    end
    if (k == 40)
      timeout("tx frame");
    @(posedge I_MCLK);
    @(negedge I_MCLK);
    chk("tx bit count", 16'(d.size()), 16'(txq.size()));
    foreach (d[i])
    begin
      chk("tx bit", {15'h0, d[i]}, {15'h0, txq[i]});
      chk("tx crc flag", {15'h0, i >= n}, {15'h0, tcq[i]});
      chk("tx last", {15'h0, i == d.size() - 1}, {15'h0, tlq[i]});
    end
    chk("irq", {15'h0, m[0]}, {15'h0, O_IRQ});
    @(posedge I_MCLK);
    chk_reg(8'h70, 8'h01);
    @(negedge I_MCLK);
    chk("irq after clear", 16'h0000, {15'h0, O_IRQ});
    @(posedge I_MCLK);
  endtask

  // --------------------------------
  // Receive frame
  // --------------------------------
  task automatic rx_frame(input int t, input int c, input bit inv, input bit en, input bit bad,
    input bit fifo, input int gap);
    int n, crc, w, k, sent;
    bit err;
    logic [15:0] dat;
    n = 1 + $unsigned($random(seed)) % 12;
    dat = 16'($random(seed));
    wr(8'h2d, {fifo, 3'(c), 2'(t), inv, en});
    crc = pre(t, c);
    for (int i = 0; i < n; i++)
      crc = step(t, crc, dat[i]);
    w = wid(t);
    sent = inv ? (~crc & msk(t)) : crc;
    // Bad frame: plain CRC in invert mode, flipped bit otherwise
    if (bad)
      sent = inv ? crc : (crc ^ 1);
    err = en && bad && (w > 0);
    nd = 0;
    ne = 0;
    nf = 0;
    nc = 0;
    i_tag.send(dat, n, 16'(sent), w, gap);
    for (k = 0; k < 20; k++)
    begin
      @(negedge I_MCLK);
      if (nd > 0)
        break;
    end
    if (k == 20)
      timeout("rx check");
    @(posedge I_MCLK);
    @(posedge I_MCLK);
    chk("rx done", 16'h0001, 16'(nd));
    chk("rx crc error", {15'h0, err}, 16'(ne));
    chk("rx fifo bits", 16'(n + (fifo ? w : 0)), 16'(nf));
    chk("rx crc bits", 16'(w), 16'(nc));
    chk_reg(8'h70, {5'h00, err, 2'b10});
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    int c;
    I_USER_PRESET <= 29'($random(seed));
    repeat (8) @(posedge I_MCLK);
    I_RST_N <= 1'b1;
    repeat (3) @(posedge I_MCLK);
    chk_reg(8'h2c, 8'h00);
    chk_reg(8'h2d, 8'h00);
    chk_reg(8'h70, 8'h00);
    chk_reg(8'h71, 8'h00);
    wr(8'h2c, 8'hff);
    chk_reg(8'h2c, 8'h7f);
    wr(8'h2d, 8'hff);
    chk_reg(8'h2d, 8'hff);
    wr(8'h40, 8'h5a);
    chk_reg(8'h40, 8'h00);
    // Write with clock enable low must not land
    I_CE <= 1'b0;
    wr(8'h71, 8'h05);
    I_CE <= 1'b1;
    chk_reg(8'h71, 8'h00);
    for (int t = 0; t < 4; t++)
      foreach (codes[j])
        if (!(t == 0 && codes[j] inside {2, 3}))
          tx_frame(t, codes[j], $random(seed), $random(seed));
    for (int t = 0; t < 4; t++)
      for (int k = 0; k < 8; k++)
      begin
        c = codes[k % 6];
        if (t == 0 && c inside {2, 3})
          c = 6;
        rx_frame(t, c, k[0], k[1], k[2], (t == 0) || $random(seed), k % 3);
      end
    close_out;
  end
endmodule
